//--- hdl/mode_ctrl_pkg.sv
package mode_ctrl_pkg;
  // register map
  localparam logic [4:0]  MODE_CTRL_ADDR   = 5'h00;
  localparam logic [15:0] MODE_CTRL_RESET  = 16'h1040;
  localparam logic [15:0] MODE_CTRL_WMASK  = 16'hffe0;
  // field positions
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_LOOPBACK   = 14;
  localparam int BIT_SPEED_LSB  = 13;
  localparam int BIT_AN_ENABLE  = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_ISOLATE    = 10;
  localparam int BIT_AN_RESTART = 9;
  localparam int BIT_DUPLEX     = 8;
  localparam int BIT_COL_TEST   = 7;
  localparam int BIT_SPEED_MSB  = 6;
  localparam int BIT_UNIDIR     = 5;
  // forced speed codes
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SPEED_RSVD = 2'h3;
  // media modes
  typedef enum logic [1:0] {
    MEDIA_COPPER = 2'b00,
    MEDIA_PROTO  = 2'b01,
    MEDIA_1000X  = 2'b10,
    MEDIA_100FX  = 2'b11
  } media_type;
  // quiet time the manager keeps after a soft reset
  localparam int SOFT_RESET_WAIT_NS = 1000;
  localparam int CLK_PERIOD_NS      = 10;
  localparam int SOFT_RESET_CYCLES  = (SOFT_RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- hdl/pulse_stretch.sv
`timescale 1ns/1ps
`default_nettype none
// holds a level high for a fixed number of cycles after a start pulse
module pulse_stretch
  import mode_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // control
  input  wire logic start,
  output logic      busy
);
  logic [7:0] count_reg;
  logic [7:0] count_next;

  // reload on start, count down otherwise
  assign count_next = start ? 8'(SOFT_RESET_CYCLES) :
                      (count_reg != 8'h00) ? count_reg - 8'h01 : 8'h00;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_reg <= 8'h00;
      busy      <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy      <= (count_next != 8'h00);
    end
  end
endmodule
`default_nettype wire

//--- hdl/port_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R1) writing 1 to bit 15 restores defaults; bit self-clears
// (R2) manager waits 1 us after soft reset before next access
// (R3) bit 14 loops data back at the selected speed and duplex
// (R4) forced speed code is bit6 high, bit13 low; 11 reserved
// (R5) forced speed resets to code 10, 1000 Mbps
// (R6) bit 10 disables MAC outputs and ignores MAC inputs
// (R7) writing 1 to bit 9 restarts autonegotiation; bit self-clears
// (R8) bit 7 enables the collision test
// (R9) unidirectional bit ignored with autonegotiation on or half duplex
// (R10) effective unidirectional bit allows transmit without valid link
// (R11) unidirectional transmit only applies in fiber modes
// (R12) manager picks master or slave before forcing 1000 Mbps
// (R13) manager powers port down after link loss in forced 1000 Mbps
// (R14) manager selects page 0 before reaching this register
// (R15) bit 11 powers down; bit 12 resets to 1, selects negotiation
// (R16) reserved bits 4..0 ignore writes and read zero
module port_mode_control
  import mode_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // serial_mgmt_port register access, page already decoded
  input  wire logic        mgmt_wr,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic [15:0] mgmt_wdata,
  output logic [15:0]      mgmt_rdata,
  output logic             mgmt_busy,
  // media side status
  input  wire media_type   media_mode,
  input  wire logic        link_valid,
  // mac side data
  input  wire logic        mac_tx_in,
  output logic             mac_tx_taken,
  output logic             mac_out_en,
  // controls towards the datapath
  output logic             soft_reset_pulse,
  output logic             an_restart_pulse,
  output logic             an_enabled,
  output logic             loopback_on,
  output logic [1:0]       speed_sel,
  output logic             full_duplex,
  output logic             power_down,
  output logic             col_test_on,
  output logic             tx_allowed
);
  ////////////////////////////////////////////////////////////////////////
  // stored copy of the register
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  wire         hit      = mgmt_wr && (mgmt_addr == MODE_CTRL_ADDR);
  wire         do_sreset = hit && mgmt_wdata[BIT_SOFT_RESET];
  wire         do_restart = hit && mgmt_wdata[BIT_AN_RESTART];
  // self-clearing bits never store, reserved bits never store
  wire [15:0]  store_mask = MODE_CTRL_WMASK &
                            ~(16'h0001 << BIT_SOFT_RESET) &
                            ~(16'h0001 << BIT_AN_RESTART); // R16

  // soft reset wins over the data written with it
  assign ctrl_next = do_sreset ? MODE_CTRL_RESET :               // R1
                     hit ? (mgmt_wdata & store_mask) : ctrl_reg; // R16

  // control register: the device reset and a soft reset both load the defaults
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= MODE_CTRL_RESET; // R5 R15
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // busy window after soft reset; writes are still taken while it is high,
  // so it is a hint for the manager rather than a lock
  pulse_stretch u_wait (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (do_sreset), // R2
    .busy  (mgmt_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // derived controls
  // unidirectional needs negotiation off, full duplex and a fiber medium
  wire       fiber    = (media_mode == MEDIA_1000X) || (media_mode == MEDIA_100FX); // R11
  wire       unidir_eff = !ctrl_next[BIT_AN_ENABLE] && ctrl_next[BIT_DUPLEX] &&
                          ctrl_next[BIT_UNIDIR] && fiber; // R9 R10 R11
  wire [1:0] speed_w  = {ctrl_next[BIT_SPEED_MSB], ctrl_next[BIT_SPEED_LSB]}; // R4
  wire       iso_w    = ctrl_next[BIT_ISOLATE];
  wire       tx_ok_w  = unidir_eff || link_valid; // R10
  // read back: self-clearing and reserved bits always read zero
  wire [15:0] rdata_w = ctrl_next & store_mask;

  // management view: the stored copy with self-clearing and reserved bits dropped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mgmt_rdata <= MODE_CTRL_RESET; // R5 R15
    end else begin
      mgmt_rdata <= rdata_w;         // R16
    end
  end

  // one-cycle strobes; a restart written together with a soft reset is dropped,
  // since the soft reset already returns negotiation to its default state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      soft_reset_pulse <= 1'b0;
      an_restart_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= do_sreset;                 // R1
      an_restart_pulse <= do_restart && !do_sreset;  // R7
    end
  end

  // mode levels towards the datapath
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      an_enabled  <= 1'b1;
      loopback_on <= 1'b0;
      speed_sel   <= SPEED_1000; // R5
      full_duplex <= 1'b0;
      power_down  <= 1'b0;
      col_test_on <= 1'b0;
    end else begin
      an_enabled  <= ctrl_next[BIT_AN_ENABLE];  // R15
      loopback_on <= ctrl_next[BIT_LOOPBACK];   // R3
      speed_sel   <= speed_w;                   // R3 R4
      full_duplex <= ctrl_next[BIT_DUPLEX];     // R3
      power_down  <= ctrl_next[BIT_POWER_DOWN]; // R15
      col_test_on <= ctrl_next[BIT_COL_TEST];   // R8
    end
  end

  // mac side gating; outputs stay disabled while reset is held and are
  // enabled by the first edge after release unless isolate is stored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_allowed   <= 1'b0;
      mac_out_en   <= 1'b1;
      mac_tx_taken <= 1'b0;
    end else begin
      tx_allowed   <= tx_ok_w && !iso_w;              // R10
      mac_out_en   <= iso_w;                          // R6 low means driving
      mac_tx_taken <= mac_tx_in && !iso_w && tx_ok_w; // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // soft reset: defaults back, one strobe, busy held for the first 8 cycles of the wait window
  sreset_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    do_sreset |=> (mgmt_rdata == MODE_CTRL_RESET) && soft_reset_pulse)
    else $error("soft reset did not restore defaults");

  sreset_once_a: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    soft_reset_pulse |-> $past(do_sreset))
    else $error("soft reset strobe without a write");

  sreset_busy_a: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    do_sreset |=> mgmt_busy [*8])
    else $error("busy window too short");

  // reset values of the mode fields
  reset_value_a: assert property (@(posedge mclk) disable iff (!rst_n) // R5 R15
    !$past(rst_n) |-> (speed_sel == SPEED_1000) && an_enabled && !power_down)
    else $error("reset values wrong");

  // restart strobe follows each restart write made without a soft reset; back to back writes are legal
  restart_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n) // R7
    do_restart && !do_sreset |=> an_restart_pulse && !mgmt_rdata[BIT_AN_RESTART])
    else $error("restart write gave no strobe");

  restart_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // R7
    !(do_restart && !do_sreset) |=> !an_restart_pulse)
    else $error("restart strobe not self clearing");

  // mode levels follow the stored fields
  speed_map_a: assert property (@(posedge mclk) disable iff (!rst_n) // R4
    speed_sel == {mgmt_rdata[BIT_SPEED_MSB], mgmt_rdata[BIT_SPEED_LSB]})
    else $error("speed code mismatch");

  loopback_map_a: assert property (@(posedge mclk) disable iff (!rst_n) // R3
    (loopback_on == mgmt_rdata[BIT_LOOPBACK]) && (full_duplex == mgmt_rdata[BIT_DUPLEX]))
    else $error("loopback or duplex mismatch");

  power_map_a: assert property (@(posedge mclk) disable iff (!rst_n) // R15
    (power_down == mgmt_rdata[BIT_POWER_DOWN]) && (an_enabled == mgmt_rdata[BIT_AN_ENABLE]))
    else $error("power down or negotiation mismatch");

  col_test_a: assert property (@(posedge mclk) disable iff (!rst_n) // R8
    col_test_on == mgmt_rdata[BIT_COL_TEST])
    else $error("collision test mismatch");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    mgmt_rdata[4:0] == 5'h00)
    else $error("reserved bits nonzero");

  // mac side gating
  isolate_out_a: assert property (@(posedge mclk) disable iff (!rst_n) // R6
    mgmt_rdata[BIT_ISOLATE] |-> mac_out_en && !mac_tx_taken)
    else $error("isolate not honoured");

  mac_taken_a: assert property (@(posedge mclk) disable iff (!rst_n) // R6 R10
    mac_tx_taken |-> tx_allowed && !mac_out_en)
    else $error("transmit taken without permission");

  unidir_ign_a: assert property (@(posedge mclk) disable iff (!rst_n) // R9
    (an_enabled || !full_duplex) && !$past(link_valid) |-> !tx_allowed)
    else $error("unidirectional bit not ignored");

  unidir_tx_a: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    $past(rst_n) && $past(unidir_eff) && !$past(iso_w) |-> tx_allowed)
    else $error("unidirectional transmit refused");

  copper_unidir_a: assert property (@(posedge mclk) disable iff (!rst_n) // R11
    $past(media_mode) == MEDIA_COPPER && !$past(link_valid) |-> !tx_allowed)
    else $error("unidirectional active in copper");
endmodule
`default_nettype wire

//--- bench/mgmt_master.sv
`timescale 1ns/1ps
`default_nettype none
// station manager model: one register write per call
module mgmt_master
  import mode_ctrl_pkg::*;
(
  // clock
  input  wire logic        mclk,
  // register access
  output logic             mgmt_wr,
  output logic [4:0]       mgmt_addr,
  output logic [15:0]      mgmt_wdata
);
  logic quiet;
  initial begin
    mgmt_wr = 1'b0;
    mgmt_addr = 5'h00;
    mgmt_wdata = 16'h0000;
    quiet = 1'b0;
  end
  // page 0 is taken as selected upstream, so address 0 is this register
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    if (quiet) repeat (SOFT_RESET_CYCLES) @(posedge mclk);
    @(posedge mclk);
    #1;
    mgmt_wr = 1'b1;
    mgmt_addr = a;
    mgmt_wdata = d;
    @(posedge mclk);
    #1;
    mgmt_wr = 1'b0;
    // released lines show no stale value
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
    quiet = (a == 5'h00) && d[15];
  endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mode_ctrl_pkg::*;
  logic mclk, rst_n, wr, lv, tin;
  logic [4:0] ad;
  logic [15:0] wd, rd;
  media_type md;
  logic busy, tk, oe, srp, arp, an, lb, fd, pd, ct, txa;
  logic [1:0] sp;
  int n_fail = 0, checks_done = 0, cyc = 0, seed = 32'ha15b;
  int q = 16'h1040;
  logic [15:0] d, x;
  logic [4:0] a;
  logic sr, ar, tx, lp;
  mgmt_master i_mgmt_master (.mclk(mclk), .mgmt_wr(wr), .mgmt_addr(ad), .mgmt_wdata(wd));
  port_mode_control i_port_mode_control (.mclk(mclk), .rst_n(rst_n), .mgmt_wr(wr),
    .mgmt_addr(ad), .mgmt_wdata(wd), .mgmt_rdata(rd), .mgmt_busy(busy), .media_mode(md),
    .link_valid(lv), .mac_tx_in(tin), .mac_tx_taken(tk), .mac_out_en(oe),
    .soft_reset_pulse(srp), .an_restart_pulse(arp), .an_enabled(an), .loopback_on(lb),
    .speed_sel(sp), .full_duplex(fd), .power_down(pd), .col_test_on(ct), .tx_allowed(txa));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // strobes and mac side results share the plain compare underneath
  task automatic chk_pulse(input logic [1:0] got, input logic [1:0] exp);
    chk({14'h0000, got}, {14'h0000, exp});
  endtask
  task automatic chk_mac(input logic [1:0] got, input logic [1:0] exp);
    chk({14'h0000, got}, {14'h0000, exp});
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // clock and a hang limit well above the ~1000 cycles the run needs
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // random writes against an integer model of the register
  initial begin
    rst_n = 1'b0;
    md = MEDIA_COPPER;
    lv = 1'b0;
    tin = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    chk(rd, 16'h1040);
    chk({an, sp, oe}, 16'h000d);
    for (int i = 0; i < 60; i++) begin
      // a hard reset in mid-run must bring back the same defaults
      if (i == 50) begin
        rst_n = 1'b0;
        @(posedge mclk);
        #1;
        rst_n = 1'b1;
        q = 16'h1040;
        chk(rd, 16'h1040);
      end
      x = $random(seed);
      d = $random(seed);
      if (x[7:5] != 3'h0) d[15] = 1'b0; // soft reset kept rare
      a = (x[4:3] == 2'h0) ? 5'h03 : 5'h00;
      md = media_type'(x[1:0]);
      lp = lv;
      lv = x[2];
      tin = x[8];
      // manager powers the port down after a link loss in forced 1000 Mbps
      if (lp && !lv && !q[12] && q[6] && !q[13]) begin
        a = 5'h00;
        d[15] = 1'b0;
        d[11] = 1'b1;
      end
      // directed cases: a soft reset, and unidirectional transmit on fiber
      if (i == 20) begin
        a = 5'h00;
        d[15] = 1'b1;
      end
      if (i == 40) begin
        a = 5'h00;
        d = 16'h0120;
        md = MEDIA_100FX;
        lv = 1'b0;
      end
      // master or slave role is chosen before any forced 1000 Mbps write
      if (a == 5'h00 && !d[15] && !d[12] && d[6] && !d[13]) begin
        i_mgmt_master.wr(5'h09, 16'h0800);
      end
      i_mgmt_master.wr(a, d);
      sr = (a == 5'h00) && d[15];
      ar = (a == 5'h00) && d[9] && !d[15];
      if (a == 5'h00) q = sr ? 16'h1040 : (d & 16'hfde0);
      chk(rd, q[15:0]);
      chk_pulse({srp, arp}, {sr, ar});
      chk(sp, {q[6], q[13]});
      chk({lb, an, pd, fd, ct}, {q[14], q[12], q[11], q[8], q[7]});
      @(posedge mclk);
      #1;
      tx = (lv || (!q[12] && q[8] && q[5] && md[1])) && !q[10];
      chk_mac(txa, tx);
      chk_mac({tk, oe}, {tin && tx, q[10]});
      chk_pulse({srp, arp}, 2'b00);
      chk(busy, sr);
      // busy must span exactly the quiet time after a soft reset
      if (sr) begin
        repeat (SOFT_RESET_CYCLES - 2) @(posedge mclk);
        #1;
        chk(busy, 1'b1);
        @(posedge mclk);
        #1;
        chk(busy, 1'b0);
      end
    end
    wrap_up;
  end
endmodule
`default_nettype wire
